// ### rtl/sroc_pkg.sv
package sroc_pkg;

    // ************************************************************
    // Frame layout
    // ************************************************************
    localparam int FRAME_BITS   = 16;
    localparam int MODE_LSB     = 0;
    localparam int MODE_W       = 3;
    localparam int SEL_LSB      = 3;
    localparam int SEL_W        = 3;
    localparam int PAY_LSB      = 6;
    localparam int PAY_W        = 10;
    localparam int REG_W        = 10;
    localparam int NUM_REGS     = 8;

    // Mode selection code for the read-only access
    localparam logic [2:0] MODE_READ_ONLY = 3'h7;
    // Register that holds the restart reason bits
    localparam logic [2:0] SEL_RESTART    = 3'h6;
    localparam int RST_HI_BIT   = 1;
    localparam int RST_LO_BIT   = 0;

    // Reset values
    localparam logic [9:0] CFG_RESET  = 10'h000;
    localparam logic [2:0] SEL_RESET  = 3'h0;

    typedef logic [REG_W-1:0] sroc_word_t;

    // Decoded command handed out at frame end
    typedef struct packed {
        logic [MODE_W-1:0] mode;
        logic [SEL_W-1:0]  sel;
        logic [PAY_W-1:0]  payload;
    } sroc_cmd_s;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_SHIFT = 3'b010,
        ST_DONE  = 3'b100
    } sroc_state_e;

endpackage

// ### rtl/sroc_spi_read_only.sv
`timescale 1ns/1ps
// How it works
// - Mode field read-only code marks read-only command
// - Read-only clears latched flags of selected register
// - Live-status flag bits are never cleared by reads
// - Read-only command writes no configuration register
// - Read-only frame requests no mode change
// - Valid read-only frame services the watchdog
// - Read-only returns selected register same frame
// - Other commands answer in the following frame
// - Restart reason bits cleared by read, sleep exit
// - Automatic first frame does not clear flags
module sroc_spi_read_only
    import sroc_pkg::*;
(
    input  wire logic                          MCLK_IN,
    input  wire logic                          RST_N_IN,
    input  wire logic                          SPI_CLK_IN,
    input  wire logic                          SPI_MOSI_IN,
    input  wire logic                          CHIP_SELECT_N_IN,
    output logic                               SPI_MISO_OUT,
    output logic                               SPI_MISO_OE_OUT,
    input  wire logic [NUM_REGS*REG_W-1:0]     STATUS_FLAGS_IN,
    input  wire logic [NUM_REGS*REG_W-1:0]     LIVE_MASK_IN,
    input  wire logic                          FIRST_FRAME_IN,
    input  wire logic [SEL_W-1:0]              FIRST_SEL_IN,
    input  wire logic                          SLEEP_EXIT_IN,
    output logic [NUM_REGS*REG_W-1:0]          FLAG_CLEAR_OUT,
    output logic                               WDOG_SERVICE_OUT,
    output logic                               CMD_VALID_OUT,
    output logic [FRAME_BITS-1:0]              CMD_OUT,
    output logic                               RESTART_HI_OUT,
    output logic                               RESTART_LO_OUT
);

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    logic [2:0] sync1;
    logic [2:0] sync2;
    // Pin idle levels {select, data, clock}: select high, data and clock low
    localparam logic [2:0] SYNC_IDLE = 3'h4;
    logic       sclk_d;
    logic [4:0] bit_cnt;
    logic [FRAME_BITS-1:0] rx_shift;
    logic [REG_W-1:0]      tx_shift;
    logic [SEL_W-1:0]      pend_sel;
    sroc_state_e           state;
    sroc_state_e           next_state;
    logic                  restart_hi;
    logic                  restart_lo;
    sroc_cmd_s             cmd;

    always_ff @(posedge MCLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            // Idle levels, so the first edges after reset neither open a
            // frame nor show a false rising edge of the link clock
            sync1 <= SYNC_IDLE;
            sync2 <= SYNC_IDLE;
        end
        else
        begin
            sync1 <= {CHIP_SELECT_N_IN, SPI_MOSI_IN, SPI_CLK_IN};
            sync2 <= sync1;
        end
    end

    wire sclk   = sync2[0];
    wire mosi   = sync2[1];
    wire cs_n   = sync2[2];
    // Edges of the link clock as seen through the synchronisers
    wire rise   = sclk & ~sclk_d;
    wire fall   = ~sclk & sclk_d;

    // ************************************************************
    // Decoding
    // ************************************************************
    // Select one register out of the packed flag vector
    function automatic sroc_word_t pick(input logic [NUM_REGS*REG_W-1:0] v,
                                        input logic [SEL_W-1:0] s);
        pick = v[s*REG_W +: REG_W];
    endfunction

    // Mode field arrives in the first bits, LSB first, so sel is known after 6 bits
    // The newest bits enter at the top, so after the header the mode and
    // select sit in the upper bits; the early view reads them there
    localparam int HDR_BASE = FRAME_BITS - (MODE_W + SEL_W);
    wire [SEL_W-1:0]  live_sel  = rx_shift[HDR_BASE + SEL_LSB +: SEL_W];
    wire [MODE_W-1:0] live_mode = rx_shift[HDR_BASE + MODE_LSB +: MODE_W];
    wire              live_ro   = (live_mode == MODE_READ_ONLY);
    wire             hdr_done  = (bit_cnt == 5'(MODE_W + SEL_W));
    wire             full      = (bit_cnt == 5'(FRAME_BITS));
    // Fields are picked by position: on the wire the mode comes first and
    // lands in the low bits, while the struct holds it as its top field
    assign cmd = {rx_shift[MODE_LSB +: MODE_W], rx_shift[SEL_LSB +: SEL_W],
                  rx_shift[PAY_LSB +: PAY_W]};
    wire             cmd_ro    = (cmd.mode == MODE_READ_ONLY);
    // Flag view as received; the restart register is replaced below by the latched reasons
    wire [NUM_REGS*REG_W-1:0] view = STATUS_FLAGS_IN;
    wire sroc_word_t rd_now   = pick(view, live_sel);
    wire sroc_word_t rd_pend  = pick(view, pend_sel);
    wire sroc_word_t rst_word = {{(REG_W-2){1'b0}}, restart_hi, restart_lo};
    // The restart register is served from the latched reasons, not the pins
    wire sroc_word_t now_word = (live_sel == SEL_RESTART) ? rst_word : rd_now;
    wire sroc_word_t old_word = (pend_sel == SEL_RESTART) ? rst_word : rd_pend;

    // ************************************************************
    // Frame state machine
    // ************************************************************
    // A frame reaches DONE only if the select rises after all 16 bits
    always_comb
    begin
        next_state = state;
        unique case (state)
            ST_IDLE:  if (!cs_n) next_state = ST_SHIFT;
            ST_SHIFT: if (cs_n)  next_state = full ? ST_DONE : ST_IDLE;
            ST_DONE:  next_state = ST_IDLE;
            default:  next_state = ST_IDLE;
        endcase
    end

    // Bits are taken on the detected rising edge; bits past 16 are ignored
    always_ff @(posedge MCLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            state    <= ST_IDLE;
            sclk_d   <= 1'b0;
            bit_cnt  <= 5'h0;
            rx_shift <= 16'h0000;
            tx_shift <= 10'h000;
        end
        else
        begin
            state  <= next_state;
            sclk_d <= sclk;
            if (state == ST_IDLE && !cs_n)
            begin
                bit_cnt  <= 5'h0;
                // Previous command's answer is loaded at frame start
                tx_shift <= old_word;
            end
            else if (state == ST_SHIFT && rise && bit_cnt < 5'(FRAME_BITS))
            begin
                // LSB first: each new bit lands above those already in
                rx_shift <= {mosi, rx_shift[FRAME_BITS-1:1]};
                bit_cnt  <= bit_cnt + 5'h1;
            end
            else if (state == ST_SHIFT && fall)
            begin
                // Read-only: the selected register replaces the old answer here
                if (hdr_done && live_ro)
                    tx_shift <= now_word;
                else
                    tx_shift <= {1'b0, tx_shift[REG_W-1:1]};
            end
        end
    end

    // Only now are all 16 bits in place; effects wait for the select to rise
    // after at least that many bits, so a truncated frame changes nothing
    // outside and its read-only flag clear is dropped with it
    // ************************************************************
    // Command effects at frame end
    // ************************************************************
    // DONE lasts one clock, so each effect is a single pulse
    wire done      = (state == ST_DONE);
    wire ro_done   = done & cmd_ro;
    // Live bits are masked out, so a read never clears a standing condition
    wire sroc_word_t clr_sel = pick(STATUS_FLAGS_IN, cmd.sel) & ~pick(LIVE_MASK_IN, cmd.sel);

    always_ff @(posedge MCLK_IN or negedge RST_N_IN)
    begin
        if (!RST_N_IN)
        begin
            pend_sel         <= SEL_RESET;
            FLAG_CLEAR_OUT   <= '0;
            WDOG_SERVICE_OUT <= 1'b0;
            CMD_VALID_OUT    <= 1'b0;
            CMD_OUT          <= 16'h0000;
            restart_hi       <= 1'b0;
            restart_lo       <= 1'b0;
        end
        else
        begin
            FLAG_CLEAR_OUT   <= '0;
            WDOG_SERVICE_OUT <= ro_done;
            CMD_VALID_OUT    <= done & ~cmd_ro;
            // Handed on in wire order, first bit received in bit 0
            if (done && !cmd_ro)
                CMD_OUT <= rx_shift;
            // The automatic first frame only picks what is reported; no clear
            if (FIRST_FRAME_IN)
                pend_sel <= FIRST_SEL_IN;
            else if (done && !cmd_ro)
                pend_sel <= cmd.sel;
            // Clear pulse covers the selected register only
            if (ro_done)
                FLAG_CLEAR_OUT[cmd.sel*REG_W +: REG_W] <= clr_sel;
            // Set beats clear: a new reason arriving now is kept
            // Sleep exit clears both reasons, as a read does
            if (STATUS_FLAGS_IN[SEL_RESTART*REG_W + RST_HI_BIT])
                restart_hi <= 1'b1;
            else if ((ro_done && cmd.sel == SEL_RESTART) || SLEEP_EXIT_IN)
                restart_hi <= 1'b0;
            if (STATUS_FLAGS_IN[SEL_RESTART*REG_W + RST_LO_BIT])
                restart_lo <= 1'b1;
            else if ((ro_done && cmd.sel == SEL_RESTART) || SLEEP_EXIT_IN)
                restart_lo <= 1'b0;
        end
    end

    // Output bits move on the detected falling edge, some three clocks
    // late; the link clock must leave the host that much margin
    assign SPI_MISO_OUT    = tx_shift[0];
    // Driven only while the frame machine shifts
    assign SPI_MISO_OE_OUT = (state == ST_SHIFT);
    assign RESTART_HI_OUT  = restart_hi;
    assign RESTART_LO_OUT  = restart_lo;

endmodule // sroc_spi_read_only

// ### test/sroc_chk.sv
`timescale 1ns/1ps
// ********************
// Port checker
// ********************
module sroc_chk
    import sroc_pkg::*;
(
    input wire logic                      MCLK_IN,
    input wire logic                      RST_N_IN,
    input wire logic                      CHIP_SELECT_N_IN,
    input wire logic                      SPI_MISO_OE_OUT,
    input wire logic [NUM_REGS*REG_W-1:0] STATUS_FLAGS_IN,
    input wire logic [NUM_REGS*REG_W-1:0] LIVE_MASK_IN,
    input wire logic                      SLEEP_EXIT_IN,
    input wire logic [NUM_REGS*REG_W-1:0] FLAG_CLEAR_OUT,
    input wire logic                      WDOG_SERVICE_OUT,
    input wire logic                      CMD_VALID_OUT,
    input wire logic [FRAME_BITS-1:0]     CMD_OUT,
    input wire logic                      RESTART_HI_OUT,
    input wire logic                      RESTART_LO_OUT
);
    localparam int RB = SEL_RESTART * REG_W;
    // One clock domain, so clocking and disable are shared
    default clocking dc @(posedge MCLK_IN);
    endclocking
    default disable iff (!RST_N_IN);
    AST_AFTER_CS: assert property ((WDOG_SERVICE_OUT || CMD_VALID_OUT) |->
        $past(CHIP_SELECT_N_IN, 2) && $past(CHIP_SELECT_N_IN, 3)) else $error("early effect");
    AST_WDOG_PULSE: assert property (WDOG_SERVICE_OUT |=> !WDOG_SERVICE_OUT)
        else $error("service pulse too long");
    AST_VALID_PULSE: assert property (CMD_VALID_OUT |=> !CMD_VALID_OUT)
        else $error("valid pulse too long");
    AST_NO_MODE_REQ: assert property (CMD_VALID_OUT |->
        CMD_OUT[MODE_W-1:0] != MODE_READ_ONLY) else $error("read-only frame passed on");
    AST_CMD_HOLD: assert property ($changed(CMD_OUT) |-> CMD_VALID_OUT)
        else $error("command changed without valid");
    AST_LIVE_KEPT: assert property ((FLAG_CLEAR_OUT & LIVE_MASK_IN) == '0)
        else $error("live bit cleared");
    AST_CLEAR_IS_RO: assert property (|FLAG_CLEAR_OUT |-> WDOG_SERVICE_OUT)
        else $error("clear outside read-only");
    AST_OE_FRAME: assert property ($rose(SPI_MISO_OE_OUT) |-> !$past(CHIP_SELECT_N_IN))
        else $error("output enabled outside frame");
    AST_SLEEP_CLR: assert property (SLEEP_EXIT_IN && !STATUS_FLAGS_IN[RB+1]
        && !STATUS_FLAGS_IN[RB] |=> !RESTART_HI_OUT && !RESTART_LO_OUT) else $error("kept");
    // Main scenarios reached
    C_WDOG: cover property (WDOG_SERVICE_OUT);
    C_VALID: cover property (CMD_VALID_OUT);
    C_CLEAR: cover property (|FLAG_CLEAR_OUT);
endmodule // sroc_chk
bind sroc_spi_read_only sroc_chk chk (.MCLK_IN(MCLK_IN), .RST_N_IN(RST_N_IN),
    .CHIP_SELECT_N_IN(CHIP_SELECT_N_IN), .SPI_MISO_OE_OUT(SPI_MISO_OE_OUT),
    .STATUS_FLAGS_IN(STATUS_FLAGS_IN), .LIVE_MASK_IN(LIVE_MASK_IN),
    .SLEEP_EXIT_IN(SLEEP_EXIT_IN), .FLAG_CLEAR_OUT(FLAG_CLEAR_OUT),
    .WDOG_SERVICE_OUT(WDOG_SERVICE_OUT), .CMD_VALID_OUT(CMD_VALID_OUT), .CMD_OUT(CMD_OUT),
    .RESTART_HI_OUT(RESTART_HI_OUT), .RESTART_LO_OUT(RESTART_LO_OUT));

// ### test/sroc_host.sv
`timescale 1ns/1ps
// ********************
// Host master model
// ********************
module sroc_host
(
    output logic      sck_out,
    output logic      mosi_out,
    output logic      cs_n_out,
    input  wire logic miso_in
);
    // Idle lines rest at their pull levels
    initial
    begin
        sck_out = 1'b0;
        mosi_out = 1'b0;
        cs_n_out = 1'b1;
    end
    // LSB first frame of n bits; half sets fast or slow clocking
    task automatic xfer(input logic [15:0] f, input int n, input int half,
                        output logic [15:0] r);
        r = '0;
        cs_n_out = 1'b0;
        #(2*half);
        for (int i = 0; i < n; i++)
        begin
            mosi_out = f[i];
            #half sck_out = 1'b1;
            r[i] = miso_in;
            #half sck_out = 1'b0;
        end
        #(2*half) cs_n_out = 1'b1;
        mosi_out = 1'b0;
        #400;
    endtask
endmodule // sroc_host

// ### test/sroc_spi_read_only_tb_top.sv
`timescale 1ns/1ps
module sroc_spi_read_only_tb_top import sroc_pkg::*;;
    logic clk, rst_n, sleep, first;
    logic [SEL_W-1:0] fsel;
    logic [79:0] flags, live, clr_acc;
    logic [15:0] rx;
    wire sck, mosi, chip_select_n, miso, oe, wdog, cv, rhi, rlo;
    wire [79:0] clr;
    wire [15:0] cmd;
    int num_errors, num_checks, wd_cnt, cv_cnt;
    // ********************
    // Clock, design, host
    // ********************
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    sroc_spi_read_only dut (.MCLK_IN(clk), .RST_N_IN(rst_n), .SPI_CLK_IN(sck),
        .SPI_MOSI_IN(mosi), .CHIP_SELECT_N_IN(chip_select_n), .SPI_MISO_OUT(miso), .SPI_MISO_OE_OUT(oe),
        .STATUS_FLAGS_IN(flags), .LIVE_MASK_IN(live), .FIRST_FRAME_IN(first),
        .FIRST_SEL_IN(fsel), .SLEEP_EXIT_IN(sleep), .FLAG_CLEAR_OUT(clr),
        .WDOG_SERVICE_OUT(wdog), .CMD_VALID_OUT(cv), .CMD_OUT(cmd),
        .RESTART_HI_OUT(rhi), .RESTART_LO_OUT(rlo));
    // A released data line shows the inverse, so a late enable shows up
    sroc_host host (.sck_out(sck), .mosi_out(mosi), .cs_n_out(chip_select_n),
        .miso_in(oe ? miso : ~miso));
    // Pulses are tallied here so no one-cycle pulse is missed
    always @(posedge clk)
    begin
        wd_cnt <= wd_cnt + int'(wdog === 1'b1);
        cv_cnt <= cv_cnt + int'(cv === 1'b1);
        clr_acc <= clr_acc | clr;
    end
    task automatic chk(input string what, input logic [79:0] exp, input logic [79:0] got);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Effects land 3 to 5 cycles after the frame, so 8 is ample
    task automatic frame(input logic [15:0] f, input int n, input int h);
        wd_cnt = 0;
        cv_cnt = 0;
        clr_acc = '0;
        host.xfer(f, n, h, rx);
        repeat (8) @(negedge clk);
    endtask
    task automatic t_read_only;
        frame({10'h3FF, 3'h2, MODE_READ_ONLY}, 16, 160);
        chk("ro data", flags[20+:10], rx[15:6]);
        chk("service", 1, wd_cnt);
        chk("no cmd", 0, cv_cnt);
        chk("clear", flags & ~live & (80'h3FF << 20), clr_acc);
        chk("oe idle", 0, oe);
    endtask
    task automatic t_write;
        frame({10'h155, 3'h3, 3'h1}, 16, 160);
        chk("reset answer", flags[0+:10], rx[9:0]);
        chk("cmd", {10'h155, 3'h3, 3'h1}, cmd);
        chk("valid", 1, cv_cnt);
        chk("no clear", 0, clr_acc);
        frame({10'h0AA, 3'h2, 3'h2}, 16, 160);
        chk("answer", flags[30+:10], rx[9:0]);
    endtask
    task automatic t_trunc;
        frame({10'h3FF, 3'h2, MODE_READ_ONLY}, 15, 160);
        chk("cut service", 0, wd_cnt);
        chk("cut clear", 0, clr_acc);
    endtask
    task automatic t_restart;
        flags[61] = 1'b1;
        @(negedge clk) flags[61] = 1'b0;
        repeat (2) @(negedge clk);
        chk("hi set", 1, rhi);
        frame({10'h000, SEL_RESTART, MODE_READ_ONLY}, 16, 160);
        chk("reason data", 10'h001 << RST_HI_BIT, rx[15:6]);
        chk("hi read", 0, rhi);
        flags[60] = 1'b1;
        @(negedge clk) flags[60] = 1'b0;
        chk("lo set", 1, rlo);
        sleep = 1'b1;
        @(negedge clk) sleep = 1'b0;
        @(negedge clk) chk("lo sleep", 0, rlo);
    endtask
    task automatic t_first;
        fsel = 3'h5;
        first = 1'b1;
        @(negedge clk) first = 1'b0;
        frame({10'h001, 3'h3, 3'h1}, 16, 160);
        chk("first", flags[50+:10], rx[9:0]);
        chk("first kept", 0, clr_acc);
    endtask
    task end_of_test;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Hang guard, far beyond the few frames sent
    initial
    begin
        #400000;
        num_errors++;
        end_of_test;
    end
    initial
    begin
        {rst_n, sleep, first, fsel, wd_cnt, cv_cnt, num_errors, num_checks} = '0;
        flags = 80'h5A3C_0E96_1B47_D2F8_6C1E;
        live = 80'h0000_0000_0000_0030_0000;
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        t_read_only;
        t_write;
        t_trunc;
        t_restart;
        t_first;
        end_of_test;
    end
endmodule // sroc_spi_read_only_tb_top
